//--- inc/pin_route_pkg.sv
// Package of register map, reset values and pin bundle types for the pin routing select.
package pin_route_pkg;

	// ****************************************
	// Register map (byte offsets)
	// ****************************************
	localparam logic [3:0] OFS_ROUTING  = 4'h0;
	localparam logic [3:0] OFS_ENABLE   = 4'h4;
	localparam logic [3:0] OFS_CF_STRB2 = 4'h8;
	localparam logic [3:0] OFS_STATUS   = 4'hC;

	// ****************************************
	// Routing values and reset values
	// ****************************************
	localparam logic [7:0] ROUTE_ATA_CF  = 8'h03;
	localparam logic [7:0] ROUTE_CARD    = 8'h0F;
	localparam logic [7:0] ROUTING_RESET = 8'h00;
	localparam logic [6:0] ENABLE_RESET  = 7'h00;
	localparam logic [3:0] CF_STRB_RESET = 4'h0;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int EN_ATA   = 0;
	localparam int EN_SD    = 1;
	localparam int EN_SM    = 2;
	localparam int EN_MS    = 3;
	localparam int EN_CF    = 4;
	localparam int EN_TIMER = 5;
	localparam int EN_SCI   = 6;
	localparam int CF_ADDR_EN_LSB = 4;
	localparam int ST_VIOL  = 2;

	typedef enum logic [1:0] {LAYOUT_NONE, LAYOUT_ATA, LAYOUT_CARD, LAYOUT_CF} layout_t;

	typedef struct packed {
		logic [7:0] port_a;
		logic [7:0] port_b;
		logic [7:0] port_m;
		logic [7:0] port_q;
		logic [7:0] port_s;
		logic [7:0] port_t;
	} pins_t;

	typedef struct packed {
		logic [7:0] tim_o;
		logic [7:0] tim_oe;
		logic [5:0] sd_o;
		logic [5:0] sd_oe;
		logic [2:0] sm_o;
		logic [2:0] sm_oe;
		logic       sci_tx;
	} periph_out_t;

	typedef struct packed {
		logic [7:0] tim_i;
		logic [5:0] sd_i;
		logic [2:0] sm_i;
		logic       sci_rx;
	} periph_in_t;

endpackage

//--- src/pin_route_select.sv
// Pin routing and module permission select for the small package option.
// Notes on behaviour
// - routing value 03 ATA/CF, 0F card layout.
// - serial transmit/receive on port S bits 5:4.
// - ATA timer channels on Q7:5, M4:3, T1:0.
// - ATA SD host on Q6:5, M4:3, T1:0.
// - ATA SD enable takes shared pins from timer.
// - card layout timer channels on port B.
// - card SD on A5:0, SmartMedia on A6, S7:6.
// - CF timer channels 7:4 on Q only if address enables clear.
// - CF timer channels 3:0 have no pins.
// - unrouted pins stay general purpose port I/O.
module pin_route_select (
	input  wire logic                        CLK_SYS_IN,
	input  wire logic                        RST_B_IN,
	input  wire logic [3:0]                  AVS_ADDRESS_IN,
	input  wire logic                        AVS_READ_IN,
	input  wire logic                        AVS_WRITE_IN,
	input  wire logic [31:0]                 AVS_WRITEDATA_IN,
	output logic      [31:0]                 AVS_READDATA_OUT,
	output logic                             AVS_WAITREQUEST_OUT,
	input  wire pin_route_pkg::pins_t        PIN_IN,
	output pin_route_pkg::pins_t             PIN_OUT,
	output pin_route_pkg::pins_t             PIN_OE_OUT,
	input  wire pin_route_pkg::pins_t        GPIO_DATA_IN,
	input  wire pin_route_pkg::pins_t        GPIO_OE_IN,
	output pin_route_pkg::pins_t             GPIO_PIN_OUT,
	input  wire pin_route_pkg::periph_out_t  PERIPH_IN,
	output pin_route_pkg::periph_in_t        PERIPH_OUT,
	output logic      [6:0]                  HOST_ENABLE_OUT
);
	import pin_route_pkg::*;

	// ****************************************
	// Registers and bus slave
	// ****************************************
	logic [7:0]  routing;
	logic [6:0]  enable;
	logic [3:0]  cf_addr_en;
	logic        viol;
	logic        wait_q;
	pins_t       pin_meta;
	pins_t       pin_sync;

	wire         req      = AVS_READ_IN | AVS_WRITE_IN;
	wire         accept   = req & ~wait_q;
	wire         wr_route = accept & AVS_WRITE_IN & (AVS_ADDRESS_IN == OFS_ROUTING);
	wire         wr_en    = accept & AVS_WRITE_IN & (AVS_ADDRESS_IN == OFS_ENABLE);
	wire         wr_cf    = accept & AVS_WRITE_IN & (AVS_ADDRESS_IN == OFS_CF_STRB2);

	// a routing value of 03 serves both ATA and CF; an enabled CF host picks CF.
	wire layout_t layout = (routing == ROUTE_CARD) ? LAYOUT_CARD :
		(routing != ROUTE_ATA_CF) ? LAYOUT_NONE :
		enable[EN_CF] ? LAYOUT_CF : LAYOUT_ATA;

	// Hosts outside the layout's permitted set are held off here as well, so a
	// software slip cannot fight a routed pin.
	wire [6:0] allowed = (layout == LAYOUT_ATA)  ? 7'h63 :
		(layout == LAYOUT_CARD) ? 7'h6E :
		(layout == LAYOUT_CF)   ? 7'h70 : 7'h00;
	wire [6:0] eff_en     = enable & allowed;
	wire       next_viol  = |(enable & ~allowed & 7'h1F);
	wire       sd_on      = eff_en[EN_SD];
	wire       sm_on      = eff_en[EN_SM];
	wire       tim_on     = eff_en[EN_TIMER];
	wire       sci_on     = eff_en[EN_SCI];

	wire [31:0] status_word = {29'h0, viol, layout};
	wire [31:0] next_rdata  =
		(AVS_ADDRESS_IN == OFS_ROUTING)  ? {24'h0, routing} :
		(AVS_ADDRESS_IN == OFS_ENABLE)   ? {25'h0, enable} :
		(AVS_ADDRESS_IN == OFS_CF_STRB2) ? {24'h0, cf_addr_en, 4'h0} :
		(AVS_ADDRESS_IN == OFS_STATUS)   ? status_word : 32'h0;

	always_ff @(posedge CLK_SYS_IN) begin
		if (!RST_B_IN) begin
			wait_q           <= 1'b1;
			AVS_READDATA_OUT <= 32'h0;
		end else begin
			wait_q           <= ~(req & wait_q);
			AVS_READDATA_OUT <= (AVS_READ_IN & wait_q) ? next_rdata : AVS_READDATA_OUT;
		end
	end

	assign AVS_WAITREQUEST_OUT = wait_q;

	always_ff @(posedge CLK_SYS_IN) begin
		if (!RST_B_IN) begin
			routing    <= ROUTING_RESET;
			enable     <= ENABLE_RESET;
			cf_addr_en <= CF_STRB_RESET;
			viol       <= 1'b0;
		end else begin
			if (wr_route)
				routing <= AVS_WRITEDATA_IN[7:0];
			if (wr_en)
				enable <= AVS_WRITEDATA_IN[6:0];
			if (wr_cf)
				cf_addr_en <= AVS_WRITEDATA_IN[CF_ADDR_EN_LSB +: 4];
			viol <= next_viol;
		end
	end

	// ****************************************
	// Pin input synchronisers
	// ****************************************
	always_ff @(posedge CLK_SYS_IN) begin
		if (!RST_B_IN) begin
			pin_meta <= '0;
			pin_sync <= '0;
		end else begin
			pin_meta <= PIN_IN;
			pin_sync <= pin_meta;
		end
	end

	// ****************************************
	// Pin routing
	// ****************************************
	wire       ata      = (layout == LAYOUT_ATA);
	wire       ata_tim  = ata & tim_on & ~sd_on;
	wire [5:0] sh_o     = sd_on ? PERIPH_IN.sd_o : {PERIPH_IN.tim_o[6:5], PERIPH_IN.tim_o[3:0]};
	wire [5:0] sh_oe    = sd_on ? PERIPH_IN.sd_oe : {PERIPH_IN.tim_oe[6:5], PERIPH_IN.tim_oe[3:0]};
	wire [5:0] sh_in    = {pin_sync.port_q[6:5], pin_sync.port_m[4:3], pin_sync.port_t[1:0]};
	wire       cf_tim   = (layout == LAYOUT_CF) & tim_on & (cf_addr_en == 4'h0);

	pins_t      next_out;
	pins_t      next_oe;
	periph_in_t next_pi;

	always_comb begin
		next_out = GPIO_DATA_IN;
		next_oe  = GPIO_OE_IN;
		next_pi  = '0;
		if (sci_on) begin
			next_out.port_s[5] = PERIPH_IN.sci_tx;
			next_oe.port_s[5]  = 1'b1;
			next_oe.port_s[4]  = 1'b0;
			next_pi.sci_rx     = pin_sync.port_s[4];
		end
		if (ata & tim_on) begin
			next_out.port_q[7] = PERIPH_IN.tim_o[7];
			next_oe.port_q[7]  = PERIPH_IN.tim_oe[7];
			next_pi.tim_i[7]   = pin_sync.port_q[7];
		end
		if (ata & (sd_on | tim_on)) begin
			{next_out.port_q[6:5], next_out.port_m[4:3], next_out.port_t[1:0]} = sh_o;
			{next_oe.port_q[6:5], next_oe.port_m[4:3], next_oe.port_t[1:0]}   = sh_oe;
		end
		if (ata & sd_on)
			next_pi.sd_i = sh_in;
		if (ata_tim)
			{next_pi.tim_i[6:5], next_pi.tim_i[3:0]} = sh_in;
		if ((layout == LAYOUT_CARD) & tim_on) begin
			next_out.port_b = PERIPH_IN.tim_o;
			next_oe.port_b  = PERIPH_IN.tim_oe;
			next_pi.tim_i   = pin_sync.port_b;
		end
		if ((layout == LAYOUT_CARD) & sd_on) begin
			next_out.port_a[5:0] = PERIPH_IN.sd_o;
			next_oe.port_a[5:0]  = PERIPH_IN.sd_oe;
			next_pi.sd_i         = pin_sync.port_a[5:0];
		end
		if ((layout == LAYOUT_CARD) & sm_on) begin
			{next_out.port_a[6], next_out.port_s[7:6]} = PERIPH_IN.sm_o;
			{next_oe.port_a[6], next_oe.port_s[7:6]}   = PERIPH_IN.sm_oe;
			next_pi.sm_i = {pin_sync.port_a[6], pin_sync.port_s[7:6]};
		end
		if (cf_tim) begin
			// Channels 3 to 0 are left without pins and read back zero.
			next_out.port_q[7:4] = PERIPH_IN.tim_o[7:4];
			next_oe.port_q[7:4]  = PERIPH_IN.tim_oe[7:4];
			next_pi.tim_i[7:4]   = pin_sync.port_q[7:4];
		end
	end

	always_ff @(posedge CLK_SYS_IN) begin
		if (!RST_B_IN) begin
			PIN_OUT         <= '0;
			PIN_OE_OUT      <= '0;
			PERIPH_OUT      <= '0;
			GPIO_PIN_OUT    <= '0;
			HOST_ENABLE_OUT <= '0;
		end else begin
			PIN_OUT         <= next_out;
			PIN_OE_OUT      <= next_oe;
			PERIPH_OUT      <= next_pi;
			GPIO_PIN_OUT    <= pin_sync;
			HOST_ENABLE_OUT <= eff_en;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge CLK_SYS_IN); endclocking
	default disable iff (!RST_B_IN);

	a_layout_decode: assert property ((routing == ROUTE_CARD) |-> layout == LAYOUT_CARD)
		else $error("Routing 0F did not select the card layout.");
	a_sci_tx_route: assert property (sci_on |=> PIN_OUT.port_s[5] == $past(PERIPH_IN.sci_tx)
		&& PIN_OE_OUT.port_s[5])
		else $error("Serial transmit not on port S bit 5.");
	a_ata_timer_route: assert property (ata_tim |=> PIN_OE_OUT.port_m[4:3]
		== $past(PERIPH_IN.tim_oe[3:2]))
		else $error("ATA timer channels 3:2 not on port M.");
	a_ata_sd_route: assert property ((ata & sd_on) |=> PIN_OUT.port_t[1:0]
		== $past(PERIPH_IN.sd_o[1:0]))
		else $error("ATA SD signals not on port T.");
	a_ata_sd_steal: assert property ((ata & sd_on) |=> PERIPH_OUT.tim_i[6:5] == 2'h0
		&& PERIPH_OUT.tim_i[3:0] == 4'h0)
		else $error("Timer still sees shared pins with SD enabled.");
	a_card_timer_route: assert property (((layout == LAYOUT_CARD) & tim_on) |=>
		PERIPH_OUT.tim_i == $past(pin_sync.port_b))
		else $error("Card timer inputs not from port B.");
	a_card_sm_route: assert property (((layout == LAYOUT_CARD) & sm_on) |=>
		PIN_OUT.port_s[7:6] == $past(PERIPH_IN.sm_o[1:0]))
		else $error("SmartMedia signals not on port S bits 7:6.");
	a_cf_addr_gate: assert property (((layout == LAYOUT_CF) & (cf_addr_en != 4'h0) & ~sci_on)
		|=> PIN_OE_OUT.port_q[7:4] == $past(GPIO_OE_IN.port_q[7:4]))
		else $error("CF timer took port Q with address enables set.");
	a_cf_low_chan: assert property ((layout == LAYOUT_CF) |=> PERIPH_OUT.tim_i[3:0] == 4'h0)
		else $error("CF timer channels 3:0 reached a pin.");
	a_gpio_default: assert property ((layout == LAYOUT_NONE & ~sci_on) |=>
		PIN_OUT == $past(GPIO_DATA_IN) && PIN_OE_OUT == $past(GPIO_OE_IN))
		else $error("Unrouted pins did not follow the port registers.");
	a_host_gate: assert property (1'b1 |=> (HOST_ENABLE_OUT & ~$past(allowed)) == 7'h00)
		else $error("A forbidden host was enabled.");

	c_ata_sd: cover property (ata & sd_on & tim_on);
	c_card_all: cover property ((layout == LAYOUT_CARD) & sd_on & sm_on & tim_on);
	c_cf_timer: cover property (cf_tim ##1 (cf_addr_en != 4'h0));
	c_bus_read: cover property (AVS_READ_IN & ~wait_q);

endmodule // pin_route_select

//--- test/pad_world.sv
// Behavioural model of the card sockets and board parts that sit on the routed pads.
module pad_world
	import pin_route_pkg::*;
(
	input  wire pin_route_pkg::pins_t pin_in,
	input  wire pin_route_pkg::pins_t oe_in,
	input  wire pin_route_pkg::pins_t ext_in,
	output pin_route_pkg::pins_t      level_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// A pad the device does not drive shows what the card or the board puts on it.
	assign level_out = (pin_in & oe_in) | (ext_in & ~oe_in);
endmodule // pad_world

//--- test/tb_top.sv
// Self-checking bench for the small package pin routing select.
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import pin_route_pkg::*;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic [3:0]  addr = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	logic [31:0] q;
	logic        waitreq;
	logic [6:0]  host_en;
	pins_t       pin_lvl;
	pins_t       pin_out;
	pins_t       pin_oe;
	pins_t       gpio_pin;
	pins_t       gpio_d = '0;
	pins_t       gpio_oe = '0;
	pins_t       ext = '0;
	periph_out_t per = '0;
	periph_in_t  per_in;
	int          failures = 0;
	int          compares = 0;
	int          cycles = 0;

	pin_route_select u_pin_route_select (
		.CLK_SYS_IN(clk), .RST_B_IN(rst_b), .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd),
		.AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata), .AVS_READDATA_OUT(rdata),
		.AVS_WAITREQUEST_OUT(waitreq), .PIN_IN(pin_lvl), .PIN_OUT(pin_out),
		.PIN_OE_OUT(pin_oe), .GPIO_DATA_IN(gpio_d), .GPIO_OE_IN(gpio_oe),
		.GPIO_PIN_OUT(gpio_pin), .PERIPH_IN(per), .PERIPH_OUT(per_in),
		.HOST_ENABLE_OUT(host_en)
	);

	pad_world u_pad_world (.pin_in(pin_out), .oe_in(pin_oe), .ext_in(ext), .level_out(pin_lvl));

	initial begin
		forever #5 clk = ~clk;
	end

	// The run needs about 110 cycles; the ceiling leaves wide margin for slow answers.
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			failures++;
			finish_test();
		end
	end

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// ****************************************
	// Avalon master: hold the request until waitrequest is sampled low.
	// ****************************************
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wr <= w;
		rd <= !w;
		wdata <= d;
		do begin
			@(posedge clk);
		end while (waitreq !== 1'b0);
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask

	task automatic t_reset;
		check(host_en, 7'h00);
		bus(1'b0, OFS_ROUTING, 32'h0);
		check(q, ROUTING_RESET);
		bus(1'b1, OFS_STATUS, 32'hFF);
		bus(1'b0, OFS_STATUS, 32'h0);
		check(q, 32'h0);
		bus(1'b0, 4'h6, 32'h0);
		check(q, 32'h0);
	endtask

	task automatic t_ata;
		per <= '{8'hA5, 8'hFF, 6'h2C, 6'h3F, 3'h5, 3'h7, 1'b1};
		ext.port_s <= 8'h10;
		bus(1'b1, OFS_ROUTING, ROUTE_ATA_CF);
		bus(1'b1, OFS_ENABLE, 32'h60);
		repeat (4) @(posedge clk);
		check({pin_out.port_q[7:5], pin_out.port_m[4:3], pin_out.port_t[1:0]}, 7'h55);
		check({pin_out.port_s[5], pin_oe.port_s[5:4], per_in.sci_rx}, 4'hD);
		bus(1'b0, OFS_STATUS, 32'h0);
		check(q[2:0], 3'h1);
		bus(1'b1, OFS_ENABLE, 32'h62);
		repeat (2) @(posedge clk);
		check({pin_out.port_q[7:5], pin_out.port_m[4:3], pin_out.port_t[1:0]}, 7'h6C);
		bus(1'b1, OFS_ENABLE, 32'h66);
		repeat (2) @(posedge clk);
		check(host_en, 7'h62);
		bus(1'b0, OFS_STATUS, 32'h0);
		check(q[2], 1'b1);
	endtask

	task automatic t_card;
		bus(1'b1, OFS_ENABLE, 32'h0);
		bus(1'b1, OFS_ROUTING, ROUTE_CARD);
		bus(1'b1, OFS_ENABLE, 32'h2E);
		repeat (2) @(posedge clk);
		check(host_en, 7'h2E);
		check(pin_out.port_b, 8'hA5);
		check({pin_out.port_a[6:0], pin_out.port_s[7:6]}, 9'h1B1);
		bus(1'b0, OFS_STATUS, 32'h0);
		check(q[2:0], 3'h2);
		repeat (2) @(posedge clk);
		check({per_in.tim_i, per_in.sd_i, per_in.sm_i}, 17'h14B65);
	endtask

	task automatic t_cf;
		bus(1'b1, OFS_ENABLE, 32'h0);
		bus(1'b1, OFS_ROUTING, ROUTE_ATA_CF);
		bus(1'b1, OFS_CF_STRB2, 32'h0);
		bus(1'b1, OFS_ENABLE, 32'h30);
		repeat (2) @(posedge clk);
		check({pin_oe.port_q[7:4], pin_out.port_q[7:4]}, 8'hFA);
		check({pin_oe.port_m[4:3], pin_oe.port_t[1:0], per_in.tim_i[3:0]}, 8'h00);
		bus(1'b0, OFS_STATUS, 32'h0);
		check(q[2:0], 3'h3);
		bus(1'b1, OFS_CF_STRB2, 32'h10);
		repeat (2) @(posedge clk);
		check(pin_oe.port_q[7:4], 4'h0);
	endtask

	task automatic t_gpio;
		bus(1'b1, OFS_ENABLE, 32'h0);
		bus(1'b1, OFS_ROUTING, 32'h0);
		gpio_d <= 48'h5A3C_C3A5_0FF0;
		gpio_oe <= '1;
		repeat (2) @(posedge clk);
		check(pin_out, 48'h5A3C_C3A5_0FF0);
		check(pin_oe, 48'hFFFF_FFFF_FFFF);
		gpio_oe <= '0;
		ext <= 48'h9669_1234_ABCD;
		repeat (5) @(posedge clk);
		check(gpio_pin, 48'h9669_1234_ABCD);
	endtask

	// A reset in mid-run must clear the outputs and the routing choice.
	task automatic t_mid_reset;
		bus(1'b1, OFS_ROUTING, ROUTE_CARD);
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		check({waitreq, host_en, rdata}, {1'b1, 7'h00, 32'h0});
		check(pin_out, 48'h0);
		rst_b <= 1'b1;
		bus(1'b0, OFS_ROUTING, 32'h0);
		check(q, ROUTING_RESET);
	endtask

	task automatic finish_test;
		if (failures == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		t_reset();
		t_ata();
		t_card();
		t_cf();
		t_gpio();
		t_mid_reset();
		finish_test();
	end
endmodule // tb_top
